// [fetch_master_model.sv]
`timescale 1ns/1ns
`default_nettype none

// Bus master stand-in: drives the serial clock and can only pull the data line low.
module fetch_master_model (
	input  wire logic i_clk_sys,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	// The bus idles high; the pull-up on the wire supplies the released level.
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// Ten system clocks per phase keeps both clock phases well above the minimum width.
	task automatic half();
		repeat (10) @(negedge i_clk_sys);
	endtask

	task automatic bus_start();
		o_sda_low = 1'b1;
		half();
		o_scl = 1'b0;
		half();
	endtask

	// A repeated start releases data, raises the clock and then opens a new transfer.
	task automatic bus_restart();
		repeat (2) @(negedge i_clk_sys);
		o_sda_low = 1'b0;
		half();
		o_scl = 1'b1;
		half();
		bus_start();
	endtask

	// The master scales the raw code; codes below 2999 come out negative.
	// Pressure to pascals
	function automatic int press_pa(input logic [13:0] code);
		return ((int'(code) - 3000) * 10000) / 16383;
	endfunction

	// Integer division truncates, so the result is whole degrees.
	// Temperature to Celsius
	function automatic int temp_c(input logic [10:0] code);
		return (int'(code) * 200) / 2047 - 50;
	endfunction

	task automatic bus_stop();
		repeat (2) @(negedge i_clk_sys);
		o_sda_low = 1'b1;
		half();
		o_scl = 1'b1;
		half();
		o_sda_low = 1'b0;
		half();
	endtask

	// Data moves a little after the clock falls, so it is never seen changing while the clock is high.
	task automatic clock_bit(input logic drive_low, output logic seen);
		repeat (2) @(negedge i_clk_sys);
		o_sda_low = drive_low;
		half();
		o_scl = 1'b1;
		half();
		seen = i_sda;
		o_scl = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] value, output logic acked);
		logic seen;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(!value[i], seen);
		end
		clock_bit(1'b0, seen);
		acked = !seen;
	endtask

	task automatic recv_byte(input logic give_ack, output logic [7:0] value);
		logic seen;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b0, seen);
			value[i] = seen;
		end
		clock_bit(give_ack, seen);
	endtask
endmodule

`default_nettype wire

// [line_sync_detect.sv]
`timescale 1ns/1ns
`default_nettype none

// Brings the serial clock and data pins into the system clock domain and
// flags the clock edges and the bus start and stop conditions as one-cycle pulses.
module line_sync_detect (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda,
	output logic      o_scl_rise,
	output logic      o_scl_fall,
	output logic      o_start,
	output logic      o_stop
);

	logic [1:0] scl_meta_reg, scl_meta_next;
	logic [1:0] sda_meta_reg, sda_meta_next;
	logic       scl_reg, scl_next;
	logic       sda_reg, sda_next;

	// Bit 0 is the first stage and only feeds bit 1; edges use bit 1 and its delayed copy.
	always_comb begin
		scl_meta_next = {scl_meta_reg[0], i_scl};
		sda_meta_next = {sda_meta_reg[0], i_sda};
		scl_next      = scl_meta_reg[1];
		sda_next      = sda_meta_reg[1];
	end

	// Lines idle high, so reset to one to avoid a false start after release.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_meta_reg <= 2'h3;
			sda_meta_reg <= 2'h3;
			scl_reg      <= 1'h1;
			sda_reg      <= 1'h1;
		end else begin
			scl_meta_reg <= scl_meta_next;
			sda_meta_reg <= sda_meta_next;
			scl_reg      <= scl_next;
			sda_reg      <= sda_next;
		end
	end

	// A data change while the clock is high marks a start (falling) or a stop (rising).
	assign o_scl      = scl_meta_reg[1];
	assign o_sda      = sda_meta_reg[1];
	assign o_scl_rise = scl_meta_reg[1] & ~scl_reg;
	assign o_scl_fall = ~scl_meta_reg[1] & scl_reg;
	assign o_start    = scl_meta_reg[1] & scl_reg & sda_reg & ~sda_meta_reg[1];
	assign o_stop     = scl_meta_reg[1] & scl_reg & ~sda_reg & sda_meta_reg[1];

endmodule

`default_nettype wire

// [pressure_temp_fetch_readout.sv]
// Behaviour
// [RL1] Master opens fetch with address plus read
// [RL2] Acknowledge own address with read bit
// [RL3] Bytes one-two: status then pressure, high first
// [RL4] Third byte: upper eight temperature bits
// [RL5] Fourth byte: low three temperature bits on top
// [RL6] Master discards low five bits of byte four
// [RL7] Master may refuse after pressure bytes
// [RL8] Master ends with refusal then stop
// [RL9] Status 00 for unread fresh result
// [RL10] Status 01 once result was read
// [RL11] Master uses only status 00 data
// [RL12] Master converts pressure code to pascals
// [RL13] Master converts temperature code to Celsius
// [RL14] Copy whole packet at transfer start
// [RL15] Output register updates only between transfers
// [RL16] Never 10 or 11; fetched turns 00 into 01
package fetch_readout_pkg;
	localparam int         ADDR_W      = 7;
	localparam logic [6:0] DEV_ADDR    = 7'h28;
	localparam int         PRESS_W     = 14;
	localparam int         TEMP_W      = 11;
	localparam int         PKT_W       = 32;
	localparam logic [4:0] PAD_BITS    = 5'h00;
	localparam logic [1:0] STAT_FRESH  = 2'h0;
	localparam logic [1:0] STAT_READ   = 2'h1;
	localparam logic [3:0] ADDR_BITS   = 4'h8;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [1:0] BYTE_LAST   = 2'h3;
	localparam logic [1:0] BYTE_PLOW   = 2'h1;
	localparam logic [1:0] BYTE_THIGH  = 2'h2;
endpackage

`timescale 1ns/1ns
`default_nettype none

module pressure_temp_fetch_readout
	import fetch_readout_pkg::*;
#(
	parameter logic [ADDR_W-1:0] P_DEV_ADDR = DEV_ADDR
) (
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_n,
	input  wire logic               i_scl,
	input  wire logic               i_sda,
	input  wire logic               i_meas_valid,
	input  wire logic [PRESS_W-1:0] i_press_code,
	input  wire logic [TEMP_W-1:0]  i_temp_code,
	output logic                    o_sda_out,
	output logic                    o_sda_oe,
	output logic [1:0]              o_status,
	output logic                    o_busy
);

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_TX, ST_RX_ACK} bus_state_t;

	logic [1:0] rst_sync_reg;
	logic       rst_n_int;
	logic       sda, scl_rise, scl_fall, start_det, stop_det;

	// Reset is asserted at once and released through two flops.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'h1};
		end
	end
	assign rst_n_int = rst_sync_reg[1];

	line_sync_detect u_sync (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (rst_n_int),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_scl      (),
		.o_sda      (sda),
		.o_scl_rise (scl_rise),
		.o_scl_fall (scl_fall),
		.o_start    (start_det),
		.o_stop     (stop_det)
	);

	bus_state_t         state_reg, state_next;
	logic [3:0]         bit_reg, bit_next;
	logic [1:0]         byte_reg, byte_next;
	logic [7:0]         addr_sh_reg, addr_sh_next;
	logic [PKT_W-1:0]   pkt_reg, pkt_next;
	logic               oe_reg, oe_next;
	logic               ack_reg, ack_next;
	logic               frame_reg, frame_next;
	logic               sent_reg, sent_next;
	logic               fetch_done;
	logic               addr_hit;
	logic [PKT_W-1:0]   packet;
	logic [1:0]         status_reg, status_next;
	logic [PRESS_W-1:0] press_reg, press_next, pend_press_reg, pend_press_next;
	logic [TEMP_W-1:0]  temp_reg, temp_next, pend_temp_reg, pend_temp_next;
	logic               pend_reg, pend_next;
	logic               commit;

	// Packet as it leaves the device, most significant bit first.
	// [RL5] packet field layout
	assign packet   = {status_reg, press_reg, temp_reg, PAD_BITS};
	assign addr_hit = (addr_sh_reg[7:1] == P_DEV_ADDR) && addr_sh_reg[0];

	// Bit-level protocol engine; the data line changes only just after a clock fall.
	always_comb begin
		state_next   = state_reg;
		bit_next     = bit_reg;
		byte_next    = byte_reg;
		addr_sh_next = addr_sh_reg;
		pkt_next     = pkt_reg;
		oe_next      = oe_reg;
		ack_next     = ack_reg;
		frame_next   = frame_reg;
		sent_next    = sent_reg;
		fetch_done   = 1'h0;
		if (start_det || stop_det) begin
			// A repeated start also closes the previous transfer.
			fetch_done = sent_reg;
			sent_next  = 1'h0;
			frame_next = start_det;
			state_next = start_det ? ST_ADDR : ST_IDLE;
			bit_next   = 4'h0;
			oe_next    = 1'h0;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					if (scl_rise && bit_reg != ADDR_BITS) begin
						addr_sh_next = {addr_sh_reg[6:0], sda};
						bit_next     = bit_reg + 4'h1;
					end else if (scl_fall && bit_reg == ADDR_BITS) begin
						// [RL2] address acknowledge
						// Writes and foreign addresses are left unanswered.
						if (addr_hit) begin
							oe_next    = 1'h1;
							state_next = ST_ADDR_ACK;
							// [RL14] packet snapshot
							pkt_next   = packet;
						end else begin
							state_next = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						// [RL3] status first
						oe_next    = ~pkt_reg[PKT_W-1];
						bit_next   = 4'h0;
						byte_next  = 2'h0;
						sent_next  = 1'h1;
						state_next = ST_TX;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						pkt_next = {pkt_reg[PKT_W-2:0], 1'h0};
						if (bit_reg[2:0] == BIT_LAST) begin
							oe_next    = 1'h0;
							state_next = ST_RX_ACK;
						end else begin
							oe_next  = ~pkt_reg[PKT_W-2];
							bit_next = bit_reg + 4'h1;
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_rise) begin
						ack_next = ~sda;
					end else if (scl_fall) begin
						// [RL4] further bytes on acknowledge
						if (ack_reg && byte_reg != BYTE_LAST) begin
							oe_next    = ~pkt_reg[PKT_W-1];
							bit_next   = 4'h0;
							byte_next  = byte_reg + 2'h1;
							state_next = ST_TX;
						end else begin
							state_next = ST_IDLE;
						end
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n_int) begin
		if (!rst_n_int) begin
			state_reg   <= ST_IDLE;
			bit_reg     <= 4'h0;
			byte_reg    <= 2'h0;
			addr_sh_reg <= 8'h00;
			pkt_reg     <= 32'h0000_0000;
			oe_reg      <= 1'h0;
			ack_reg     <= 1'h0;
			frame_reg   <= 1'h0;
			sent_reg    <= 1'h0;
		end else begin
			state_reg   <= state_next;
			bit_reg     <= bit_next;
			byte_reg    <= byte_next;
			addr_sh_reg <= addr_sh_next;
			pkt_reg     <= pkt_next;
			oe_reg      <= oe_next;
			ack_reg     <= ack_next;
			frame_reg   <= frame_next;
			sent_reg    <= sent_next;
		end
	end

	// A result waits in the pending copy while a frame is open, so the bytes stay coherent.
	assign commit = pend_reg && !frame_reg;

	// Result store and freshness status.
	always_comb begin
		pend_next       = pend_reg;
		pend_press_next = pend_press_reg;
		pend_temp_next  = pend_temp_reg;
		press_next      = press_reg;
		temp_next       = temp_reg;
		status_next     = status_reg;
		if (commit) begin
			pend_next = 1'h0;
		end
		// A new result arriving on the commit cycle is kept, not lost.
		if (i_meas_valid) begin
			pend_next       = 1'h1;
			pend_press_next = i_press_code;
			pend_temp_next  = i_temp_code;
		end
		// [RL15] update between frames
		if (commit) begin
			press_next  = pend_press_reg;
			temp_next   = pend_temp_reg;
			// [RL9] fresh result
			status_next = STAT_FRESH;
		end else if (fetch_done) begin
			// [RL10] [RL16] mark as read
			status_next = STAT_READ;
		end
	end

	// Until the first result the store reads as already fetched.
	always_ff @(posedge i_clk_sys or negedge rst_n_int) begin
		if (!rst_n_int) begin
			pend_reg       <= 1'h0;
			pend_press_reg <= 14'h0000;
			pend_temp_reg  <= 11'h000;
			press_reg      <= 14'h0000;
			temp_reg       <= 11'h000;
			status_reg     <= STAT_READ;
		end else begin
			pend_reg       <= pend_next;
			pend_press_reg <= pend_press_next;
			pend_temp_reg  <= pend_temp_next;
			press_reg      <= press_next;
			temp_reg       <= temp_next;
			status_reg     <= status_next;
		end
	end

	// The pin is open drain, so the driven level is always low.
	assign o_sda_out = 1'h0;
	assign o_sda_oe  = oe_reg;
	assign o_status  = status_reg;
	assign o_busy    = frame_reg;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!rst_n_int);

	a_addr_ack: assert property (state_reg == ST_ADDR && scl_fall && bit_reg == ADDR_BITS && addr_hit // [RL2]
		&& !start_det && !stop_det |=> oe_reg && state_reg == ST_ADDR_ACK) else $error("address not acknowledged");
	a_pkt_snap: assert property (state_reg == ST_ADDR_ACK && $past(state_reg) == ST_ADDR // [RL14]
		|-> pkt_reg == $past(packet)) else $error("packet not captured at transfer start");
	a_status_msb: assert property (state_reg == ST_TX && byte_reg == 2'h0 && bit_reg == 4'h0 // [RL3]
		|-> oe_reg == ~status_reg[1] && pkt_reg[31:30] == status_reg) else $error("status not first");
	a_press_low: assert property (state_reg == ST_TX && byte_reg == BYTE_PLOW && bit_reg == 4'h0 // [RL3]
		|-> pkt_reg[31:24] == press_reg[7:0]) else $error("pressure low byte wrong");
	a_temp_high: assert property (state_reg == ST_TX && byte_reg == BYTE_THIGH && bit_reg == 4'h0 // [RL4]
		|-> pkt_reg[31:24] == temp_reg[10:3]) else $error("temperature high byte wrong");
	a_temp_low: assert property (state_reg == ST_TX && byte_reg == BYTE_LAST && bit_reg == 4'h0 // [RL5]
		|-> pkt_reg[31:24] == {temp_reg[2:0], PAD_BITS}) else $error("temperature low byte wrong");
	a_fresh_set: assert property (pend_reg && !frame_reg |=> status_reg == STAT_FRESH // [RL9]
		&& press_reg == $past(pend_press_reg)) else $error("fresh result not published");
	a_read_mark: assert property (sent_reg && (start_det || stop_det) && !commit // [RL10]
		|=> status_reg == STAT_READ) else $error("fetched result not marked");
	a_no_high_code: assert property (status_reg[1] == 1'h0) else $error("unused status code shown"); // [RL16]
	a_hold_frame: assert property (frame_reg && !start_det && !stop_det ##1 frame_reg // [RL15]
		|-> $stable(press_reg) && $stable(temp_reg) && $stable(status_reg))
		else $error("output register changed inside frame");

	c_full_read: cover property (state_reg == ST_RX_ACK && byte_reg == BYTE_LAST && scl_fall);
	c_early_end: cover property (state_reg == ST_RX_ACK && byte_reg == BYTE_PLOW && !ack_reg && scl_fall);
	c_late_commit: cover property (frame_reg && pend_reg ##1 !frame_reg ##1 status_reg == STAT_FRESH);
	c_marked_read: cover property (status_reg == STAT_FRESH ##1 status_reg == STAT_READ);

endmodule

`default_nettype wire

// [pressure_temp_fetch_readout_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); end end

module pressure_temp_fetch_readout_tb_top;
	import fetch_readout_pkg::*;

	logic               clk_sys;
	logic               rst_n;
	logic               meas_valid;
	logic [PRESS_W-1:0] press;
	logic [TEMP_W-1:0]  temp;
	logic               scl;
	logic               m_low;
	logic               sda_out;
	logic               sda_oe;
	logic [1:0]         status;
	logic               busy;
	logic               ack;
	logic [7:0]         got [4];
	int                 mismatches;
	int                 samples_checked;
	wire                sda;

	// Open-drain data wire with pull-up: high unless some party pulls it low.
	assign sda = !(m_low || (sda_oe && !sda_out));

	pressure_temp_fetch_readout pressure_temp_fetch_readout_inst (
		.i_clk_sys    (clk_sys),
		.i_rst_n      (rst_n),
		.i_scl        (scl),
		.i_sda        (sda),
		.i_meas_valid (meas_valid),
		.i_press_code (press),
		.i_temp_code  (temp),
		.o_sda_out    (sda_out),
		.o_sda_oe     (sda_oe),
		.o_status     (status),
		.o_busy       (busy)
	);

	fetch_master_model fetch_master_model_inst (
		.i_clk_sys (clk_sys),
		.i_sda     (sda),
		.o_scl     (scl),
		.o_sda_low (m_low)
	);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = !clk_sys;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// A status that never arrives ends the run instead of hanging it.
	task automatic wait_status(input logic [1:0] exp);
		int n;
		n = 0;
		while (status !== exp && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		`CHECK(status, exp)
		if (status !== exp) begin
			complete_run();
		end
	endtask

	task automatic publish(input logic [PRESS_W-1:0] p, input logic [TEMP_W-1:0] t);
		@(negedge clk_sys);
		press = p;
		temp = t;
		meas_valid = 1'b1;
		@(negedge clk_sys);
		meas_valid = 1'b0;
	endtask

	// One read transfer of n bytes; with mid set a new result arrives after the first byte.
	task automatic fetch(input int n, input logic mid);
		fetch_master_model_inst.bus_start();
		fetch_master_model_inst.send_byte({DEV_ADDR, 1'b1}, ack);
		`CHECK({ack, busy}, 2'h3)
		for (int k = 0; k < n; k++) begin
			fetch_master_model_inst.recv_byte(k < n - 1, got[k]);
			if (mid && k == 0) begin
				publish(14'h1234, 11'h456);
				repeat (3) @(negedge clk_sys);
				`CHECK(status, STAT_READ)
			end
		end
		fetch_master_model_inst.bus_stop();
		`CHECK(busy, 1'b0)
	endtask

	// The master masks the unused low bits of the last byte before comparing.
	task automatic check_packet(input logic [1:0] s, input logic [PRESS_W-1:0] p, input logic [TEMP_W-1:0] t);
		`CHECK(got[0], {s, p[PRESS_W-1:8]})
		`CHECK(got[1], p[7:0])
		`CHECK(got[2], t[TEMP_W-1:3])
		`CHECK(got[3] & 8'hE0, {t[2:0], 5'h00})
	endtask

	task automatic t_fresh_then_again();
		`CHECK({status, sda_oe, busy}, {STAT_READ, 2'h0})
		publish(14'h2A5C, 11'h5B3);
		wait_status(STAT_FRESH);
		fetch(4, 1'b0);
		check_packet(STAT_FRESH, 14'h2A5C, 11'h5B3);
		`CHECK(fetch_master_model_inst.temp_c({got[2], got[3][7:5]}), 92)
		wait_status(STAT_READ);
		fetch(4, 1'b0);
		check_packet(STAT_READ, 14'h2A5C, 11'h5B3);
		$display("done: fresh fetch and repeated fetch");
	endtask

	// Early refusal after the pressure bytes still marks the result as read.
	task automatic t_early_stop();
		publish(14'h3FFF, 11'h7FF);
		wait_status(STAT_FRESH);
		fetch(2, 1'b0);
		`CHECK({got[0], got[1]}, {STAT_FRESH, 14'h3FFF})
		`CHECK(fetch_master_model_inst.press_pa({got[0][5:0], got[1]}), 8168)
		wait_status(STAT_READ);
		$display("done: early stop");
	endtask

	// A result arriving mid-transfer must not disturb the bytes already loaded.
	task automatic t_update_mid();
		fetch(4, 1'b1);
		check_packet(STAT_READ, 14'h3FFF, 11'h7FF);
		wait_status(STAT_FRESH);
		fetch(4, 1'b0);
		check_packet(STAT_FRESH, 14'h1234, 11'h456);
		$display("done: update during transfer");
	endtask

	// A repeated start closes the first fetch, so the second one already reports the result as read.
	task automatic t_restart();
		publish(14'h0ABC, 11'h123);
		wait_status(STAT_FRESH);
		fetch_master_model_inst.bus_start();
		fetch_master_model_inst.send_byte({DEV_ADDR, 1'b1}, ack);
		fetch_master_model_inst.recv_byte(1'b0, got[0]);
		fetch_master_model_inst.bus_restart();
		fetch_master_model_inst.send_byte({DEV_ADDR, 1'b1}, ack);
		fetch_master_model_inst.recv_byte(1'b0, got[1]);
		`CHECK({busy, got[0], got[1]}, {1'b1, STAT_FRESH, 6'h0A, STAT_READ, 6'h0A})
		fetch_master_model_inst.bus_stop();
		`CHECK(status, STAT_READ)
		$display("done: repeated start");
	endtask

	task automatic t_refused();
		logic [7:0] addrs [2];
		addrs = '{{DEV_ADDR, 1'b0}, 8'h53};
		foreach (addrs[i]) begin
			fetch_master_model_inst.bus_start();
			fetch_master_model_inst.send_byte(addrs[i], ack);
			`CHECK(ack, 1'b0)
			fetch_master_model_inst.bus_stop();
		end
		`CHECK(status, STAT_READ)
		$display("done: refused addresses");
	endtask

	initial begin
		mismatches = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		meas_valid = 1'b0;
		press = '0;
		temp = '0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (10) @(negedge clk_sys);
		t_fresh_then_again();
		t_early_stop();
		t_update_mid();
		t_restart();
		t_refused();
		complete_run();
	end
endmodule

`default_nettype wire
